// file: shared/odcr_consts.vh
/*
 * Constants for the output driver configuration register bank:
 * register offsets, field positions, reset values and encodings.
 * Assumes inclusion by bare name from the design file.
 */
`ifndef ODCR_CONSTS_VH
`define ODCR_CONSTS_VH

// ----------------------------------------
// Register offsets (printed, not all multiples of four: index * 4)
// ----------------------------------------
`define ODCR_IDX_OUT0CTL 8'h1f
`define ODCR_IDX_OUT1CTL 8'h20
`define ODCR_IDX_PWDN 8'h1e

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ODCR_SRC_BIT 7
`define ODCR_FMT_HI 6
`define ODCR_FMT_LO 5
`define ODCR_MODEA_HI 4
`define ODCR_MODEA_LO 3
`define ODCR_MODEB_HI 2
`define ODCR_MODEB_LO 1
`define ODCR_PWDN_BIT 0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ODCR_RST_SRC 1'h1
`define ODCR_RST_FMT 2'h1
`define ODCR_RST_MODEA 2'h2
`define ODCR_RST_MODEB 2'h0
`define ODCR_RST_PWDN 1'h0

// ----------------------------------------
// Driver format encoding
// ----------------------------------------
`define ODCR_FMT_OFF 2'h0
`define ODCR_FMT_ACDIFF 2'h1
`define ODCR_FMT_HCSL 2'h2
`define ODCR_FMT_CMOS 2'h3

`endif

// file: verilog/odcr_output_driver_config_regs.v
/*
 * Register bank for output channels zero and one: shared source select,
 * driver format and two mode fields per channel, plus the shared
 * power-down bit. Classic Wishbone slave, 32-bit data, one word per
 * register. Assumes a single clock, synchronous active-low reset and
 * an analog driver that consumes the decoded control outputs.
 */
// Summary of operation
// - Bit 7 of channel-zero register picks shared source; 1 = synth two, reset 1.
// - Bits 6:5 of channel-zero register set its driver format, reset 1.
// - Bits 6:5 of channel-one register set its driver format, reset 1.
// - Channel-zero bits 4:3: tail current or positive CMOS leg, reset 2.
// - Channel-one bits 4:3 use the same encoding, reset 2.
// - Channel-zero bits 2:1: HCSL load or negative CMOS leg, reset 0.
// - Channel-one bits 2:1 use the same encoding, reset 0.
`timescale 1ns/1ps
`include "odcr_consts.vh"

module odcr_output_driver_config_regs #(
    parameter ADDR_WIDTH = 8
) (
    input wire clock,
    input wire rst_b,
    input wire clockEnable,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [ADDR_WIDTH-1:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg pair01SourceSelect,
    output reg pair01PowerDown,
    output reg [1:0] ch0Format,
    output reg [1:0] ch0DriveModeA,
    output reg [1:0] ch0DriveModeB,
    output reg [1:0] ch1Format,
    output reg [1:0] ch1DriveModeA,
    output reg [1:0] ch1DriveModeB,
    output reg ch0Enabled,
    output reg ch1Enabled,
    output reg pair01PathOff
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function [ADDR_WIDTH-1:0] byteAddr;
        input [7:0] idx;
        begin
            byteAddr = {idx[ADDR_WIDTH-3:0], 2'b00};
        end
    endfunction

    wire request = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire hitOut0 = (wb_adr_i == byteAddr(`ODCR_IDX_OUT0CTL));
    wire hitOut1 = (wb_adr_i == byteAddr(`ODCR_IDX_OUT1CTL));
    wire hitPwdn = (wb_adr_i == byteAddr(`ODCR_IDX_PWDN));
    wire doWrite = request & wb_we_i & wb_sel_i[0];

    // ----------------------------------------
    // Register images
    // ----------------------------------------
    wire [7:0] out0Image = {pair01SourceSelect, ch0Format, ch0DriveModeA,
        ch0DriveModeB, 1'b0};
    wire [7:0] out1Image = {1'b0, ch1Format, ch1DriveModeA,
        ch1DriveModeB, 1'b0};
    wire [7:0] pwdnImage = {7'h00, pair01PowerDown};

    reg [31:0] readMux;
    always @* begin
        readMux = 32'h00000000;
        if (hitOut0) begin
            readMux = {24'h000000, out0Image};
        end else if (hitOut1) begin
            readMux = {24'h000000, out1Image};
        end else if (hitPwdn) begin
            readMux = {24'h000000, pwdnImage};
        end
    end

    // ----------------------------------------
    // Bus slave and registers
    // ----------------------------------------
    // Unmapped addresses ack with zero data rather than hang the bus
    always @(posedge clock) begin
        if (!rst_b) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
            pair01SourceSelect <= `ODCR_RST_SRC;
            ch0Format <= `ODCR_RST_FMT;
            ch1Format <= `ODCR_RST_FMT;
            ch0DriveModeA <= `ODCR_RST_MODEA;
            ch1DriveModeA <= `ODCR_RST_MODEA;
            ch0DriveModeB <= `ODCR_RST_MODEB;
            ch1DriveModeB <= `ODCR_RST_MODEB;
            pair01PowerDown <= `ODCR_RST_PWDN;
        end else if (clockEnable) begin
            wb_ack_o <= request;
            if (request) begin
                wb_dat_o <= readMux;
            end
            if (doWrite && hitOut0) begin
                pair01SourceSelect <= wb_dat_i[`ODCR_SRC_BIT];
                ch0Format <= wb_dat_i[`ODCR_FMT_HI:`ODCR_FMT_LO];
                ch0DriveModeA <= wb_dat_i[`ODCR_MODEA_HI:`ODCR_MODEA_LO];
                ch0DriveModeB <= wb_dat_i[`ODCR_MODEB_HI:`ODCR_MODEB_LO];
            end
            if (doWrite && hitOut1) begin
                ch1Format <= wb_dat_i[`ODCR_FMT_HI:`ODCR_FMT_LO];
                ch1DriveModeA <= wb_dat_i[`ODCR_MODEA_HI:`ODCR_MODEA_LO];
                ch1DriveModeB <= wb_dat_i[`ODCR_MODEB_HI:`ODCR_MODEB_LO];
            end
            if (doWrite && hitPwdn) begin
                pair01PowerDown <= wb_dat_i[`ODCR_PWDN_BIT];
            end
        end
    end

    // ----------------------------------------
    // Driver status
    // ----------------------------------------
    // Power-down stops mux and divider only once both formats are zero; each buffer stays on until its format is zero
    always @(posedge clock) begin
        if (!rst_b) begin
            ch0Enabled <= 1'b1;
            ch1Enabled <= 1'b1;
            pair01PathOff <= 1'b0;
        end else if (clockEnable) begin
            ch0Enabled <= (ch0Format != `ODCR_FMT_OFF);
            ch1Enabled <= (ch1Format != `ODCR_FMT_OFF);
            pair01PathOff <= pair01PowerDown && (ch0Format == `ODCR_FMT_OFF)
                && (ch1Format == `ODCR_FMT_OFF);
        end
    end

endmodule

// file: testbench/odcr_props.sv
/* Checker for the odcr bank: write effects and reserved bits.
   Assumes a bind onto the design top, one clock domain. */
`timescale 1ns/1ps
module odcr_props (input wire clock, input wire rst_b, input wire clockEnable,
    input wire wb_cyc_i, input wire wb_stb_i, input wire wb_we_i, input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i, input wire [31:0] wb_dat_i, input wire [31:0] wb_dat_o,
    input wire wb_ack_o, input wire pair01SourceSelect, input wire [1:0] ch0Format,
    input wire [1:0] ch0DriveModeA, input wire [1:0] ch0DriveModeB, input wire [1:0] ch1Format,
    input wire [1:0] ch1DriveModeA, input wire [1:0] ch1DriveModeB);
    reg [31:0] dat_reg;
    wire tk = wb_cyc_i && wb_stb_i && !wb_ack_o && clockEnable;
    always @(posedge clock) dat_reg <= wb_dat_i;
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);
    sequence w0; tk && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h7c; endsequence
    sequence w1; tk && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h80; endsequence
    sequence r1; tk && !wb_we_i && wb_adr_i == 8'h80; endsequence
    src_sel_a: assert property (w0 |=> pair01SourceSelect == dat_reg[7])
        else $error("source select");
    fmt_zero_a: assert property (w0 |=> ch0Format == dat_reg[6:5])
        else $error("format zero");
    fmt_one_a: assert property (w1 |=> ch1Format == dat_reg[6:5])
        else $error("format one");
    tail_zero_a: assert property (w0 |=> ch0DriveModeA == dat_reg[4:3])
        else $error("mode a zero");
    tail_one_a: assert property (w1 |=> ch1DriveModeA == dat_reg[4:3])
        else $error("mode a one");
    load_zero_a: assert property (w0 |=> ch0DriveModeB == dat_reg[2:1])
        else $error("mode b zero");
    load_one_a: assert property (w1 |=> ch1DriveModeB == dat_reg[2:1])
        else $error("mode b one");
    resv_read_a: assert property (r1 |=> (wb_dat_o[7:0] & 8'h81) == 8'h00)
        else $error("reserved bits");
endmodule
bind odcr_output_driver_config_regs odcr_props u_props (.*);

// file: testbench/tb_output_driver_config_regs.sv
/* Bench for the odcr bank: Wishbone reads and writes, port and readback checks.
   Assumes the design and its checker are compiled first. */
`timescale 1ns/1ps
module tb_output_driver_config_regs;
    logic clock = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, ack, src, pd;
    logic [7:0] wb_adr_i = 0;
    logic [3:0] wb_sel_i = 0;
    logic [31:0] wb_dat_i = 0, dout, d = 32'h32c4afc2;
    logic [1:0] f0, a0, b0, f1, a1, b1;
    logic e0, e1, pOff;
    logic [7:0] r[3] = '{8'h00, 8'hb0, 8'h30};
    logic [7:0] m[3] = '{8'h01, 8'hfe, 8'h7e};
    logic [31:0] expQ[$];
    int err_total = 0, checked = 0;
    always #2 clock = ~clock;
    odcr_output_driver_config_regs DUT (.clock(clock), .rst_b(rst_b), .clockEnable(1'b1),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(dout), .wb_ack_o(ack),
        .pair01SourceSelect(src), .pair01PowerDown(pd), .ch0Format(f0), .ch0DriveModeA(a0),
        .ch0DriveModeB(b0), .ch1Format(f1), .ch1DriveModeA(a1), .ch1DriveModeB(b1),
        .ch0Enabled(e0), .ch1Enabled(e1), .pair01PathOff(pOff));
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic close_out;
        if (err_total == 0 && checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Request held until ack is sampled, then one idle cycle
    task automatic wbx(input logic we, input logic [7:0] a, input logic [31:0] v,
        input logic [3:0] s);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, we, a, v, s};
        do @(posedge clock); while (ack !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clock);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        expQ.push_back(e);
        wbx(1'b0, a, lfsr(e), 4'hf);
    endtask
    always @(posedge clock)
        if (ack === 1'b1 && !wb_we_i)
            check("rdata", dout, expQ.pop_front());
    initial begin
        #20000;
        err_total++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        rd(8'h7c, 32'hb0);
        rd(8'h80, 32'h30);
        rd(8'h40, 32'h0);
        // Sel bit zero drops about half the writes
        for (int i = 0; i < 30; i++) begin
            d = lfsr(d);
            wbx(1'b1, 8'h78 + 8'(4 * (i % 3)), d, {3'h7, d[9]});
            if (d[9]) r[i % 3] = d[7:0] & m[i % 3];
            check("ports", {pd, src, f0, a0, b0, f1, a1, b1},
                {r[0][0], r[1][7:1], r[2][6:1]});
            check("ch0 enabled", e0, r[1][6:5] != 2'h0);
            check("ch1 enabled", e1, r[2][6:5] != 2'h0);
            rd(8'h78 + 8'(4 * (i % 3)), {24'h0, r[i % 3]});
        end
        // Full shutdown: power-down plus both formats cleared by software
        wbx(1'b1, 8'h78, 32'h1, 4'h1);
        wbx(1'b1, 8'h7c, 32'h0, 4'h1);
        check("path on", pOff, 1'b0);
        wbx(1'b1, 8'h80, 32'h0, 4'h1);
        check("path off", pOff, 1'b1);
        check("ch0 off", e0, 1'b0);
        check("ch1 off", e1, 1'b0);
        close_out();
    end
endmodule
